// ==== bench/mpc_scan_tester.sv ====
`timescale 1ns/1ns
`default_nettype none
module mpc_scan_tester (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  // test clock stands low and select idles high (pull-up) between frames
  initial begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // hold select at a level with no test clock running
  task automatic select(input logic v);
    tms_o = v;
  endtask

  // n test clocks of 800 ns; data and select set half a period before rise
  task automatic clocks(input int n, input logic sel, input logic [7:0] bits);
    #17;
    for (int i = 0; i < n; i++) begin
      tms_o = sel;
      tdi_o = bits[i];
      #400 tck_o = 1'h1;
      #400 tck_o = 1'h0;
    end
    // a released data line must not pass for the last bit
    tdi_o = ~tdi_o;
    tms_o = 1'h1;
  endtask
endmodule // mpc_scan_tester
`default_nettype wire

// ==== bench/multifunction_pin_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module multifunction_pin_control_tb;
  // short delays keep the run brief; expectations derive from these
  localparam int ENTRY = 4;
  localparam int EXIT = 20;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic mode, lp, cks, wdec, tdo, sout;
  logic diag_clk, diag_sin, own, stms, stdi, scap, core_en;
  logic [7:0] paddr, hist;
  logic [31:0] pwdata, prdata;
  logic [12:0] pad_b, pad_o, pad_oe, user_o, user_oe, user_in;
  logic [15:0] node;
  logic [3:0] qclk;
  wire tck;
  wire tms;
  wire tdi;
  wire [12:0] pad_w;
  int failures, tests_run, ncap;

  // test clock and test data pads come from the tester
  assign pad_w = {pad_b[12:7], tdi, tck, pad_b[4:0]};

  mpc_scan_tester eq (.tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  mpc_pin_ctrl #(.NODES(16), .ENTRY_CYC(ENTRY), .EXIT_CYC(EXIT)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .mode_pin_i(mode), .low_power_pin_i(lp), .test_mode_sel_i(tms),
    .pad_i(pad_w), .pad_o(pad_o), .pad_oe_o(pad_oe), .user_o_i(user_o),
    .user_oe_i(user_oe), .user_in_o(user_in), .design_node_i(node),
    .diag_sout_data_i(sout), .checksum_active_i(cks),
    .wide_decode_i(wdec), .scan_tdo_i(tdo), .diag_clk_o(diag_clk),
    .diag_sin_o(diag_sin), .scan_own_o(own), .scan_tms_o(stms),
    .scan_tdi_o(stdi), .scan_capture_o(scap), .qclk_net_o(qclk),
    .core_enable_o(core_en));

  always #50 clk = ~clk;

  // capture pulses sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (scap === 1'h1) begin
      ncap++;
      hist = {hist[6:0], stdi};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // values read here are those standing before the edge updates them
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) failures++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h0c, 32'hff);
    rd(8'h0c, 32'h2);
    apb(1'h0, 8'h10, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_mode;
    cyc(4);
    chk(pad_oe, user_oe);
    chk(pad_o[4:0], user_o[4:0]);
    chk(diag_sin, 1'h0);
    chk(user_in[1:0], 2'h3);
    wr(8'h04, 32'h53);
    @(posedge clk) mode <= 1'h1;
    cyc(4);
    chk(pad_oe[4:0], 5'h1c);
    chk({diag_clk, diag_sin}, 2'h3);
    chk(pad_o[4:2], 3'h3);
    chk(user_in[1:0], 2'h0);
    @(posedge clk) node <= 16'h0020;
    cyc(3);
    chk(pad_o[4:3], 2'h2);
    @(posedge clk) mode <= 1'h0;
    cyc(4);
    chk(pad_oe, user_oe);
    $display("test mode done");
  endtask

  task automatic t_lock;
    wr(8'h08, 32'h1);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h1);
    @(posedge clk) mode <= 1'h1;
    cyc(4);
    chk(pad_oe[4:3], 2'h0);
    @(posedge clk) mode <= 1'h0;
    cyc(4);
    $display("test lock done");
  endtask

  task automatic t_cksum;
    @(posedge clk) cks <= 1'h1;
    cyc(4);
    chk({pad_oe[2], pad_o[2]}, 2'h3);
    @(posedge clk) cks <= 1'h0;
    cyc(4);
    chk({pad_oe[2], pad_o[2]}, {user_oe[2], user_o[2]});
    $display("test checksum done");
  endtask

  task automatic t_pins;
    wr(8'h00, 32'h14);
    rd(8'h00, 32'h14);
    @(posedge clk) wdec <= 1'h1;
    cyc(3);
    chk({pad_oe[8], pad_o[8]}, 2'h3);
    chk({qclk[0], pad_oe[9]}, 2'h2);
    chk({pad_oe[10], user_in[10]}, 2'h3);
    wr(8'h00, 32'h0);
    cyc(3);
    chk(pad_oe, user_oe);
    $display("test pins done");
  endtask

  // bounded ownership: claimed by select low, freed by 5 high clocks
  task automatic t_scan;
    wr(8'h00, 32'h1);
    eq.select(1'h0);
    cyc(4);
    chk({own, pad_o[7], pad_oe[7:5]}, 5'h14);
    chk(stms, 1'h0);
    ncap = 0;
    eq.clocks(3, 1'h0, 8'h06);
    cyc(4);
    chk({ncap[3:0], hist[2:0]}, 7'h1b);
    eq.clocks(4, 1'h1, 8'h00);
    cyc(4);
    chk(own, 1'h1);
    eq.clocks(1, 1'h1, 8'h00);
    cyc(4);
    chk({own, pad_oe[7:5]}, 4'h7);
    wr(8'h00, 32'h0);
    eq.select(1'h0);
    cyc(4);
    chk({own, pad_oe[6:5]}, 3'h3);
    eq.select(1'h1);
    wr(8'h00, 32'h3);
    cyc(4);
    eq.clocks(5, 1'h1, 8'h00);
    cyc(4);
    chk(own, 1'h1);
    wr(8'h00, 32'h0);
    $display("test scan done");
  endtask

  task automatic t_lowpow;
    @(posedge clk) lp <= 1'h1;
    cyc(ENTRY + 3);
    chk(core_en, 1'h1);
    cyc(2);
    chk({core_en, pad_oe, user_in}, 27'h0);
    @(posedge clk) lp <= 1'h0;
    cyc(EXIT - 1);
    chk(core_en, 1'h0);
    cyc(1);
    chk({core_en, pad_oe}, {1'h1, user_oe});
    $display("test low power done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    {psel, penable, pwrite, mode, lp, cks, wdec, tdo} = 8'h0;
    sout = 1'h1;
    paddr = 8'h0;
    pwdata = 32'h0;
    pad_b = 13'h0603;
    user_o = 13'h0aaa;
    user_oe = 13'h1eff;
    node = 16'h0008;
    hist = 8'h0;
    failures = 0;
    tests_run = 0;
    ncap = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    t_regs;
    t_mode;
    t_lock;
    t_cksum;
    t_pins;
    t_scan;
    t_lowpow;
    complete_run;
  end

  // whole run is some tens of microseconds; this cuts a hang short
  initial begin
    #3000000;
    failures++;
    complete_run;
  end
endmodule // multifunction_pin_control_tb
`default_nettype wire

// ==== rtl/mpc_consts.svh ====
`ifndef MPC_CONSTS_SVH
`define MPC_CONSTS_SVH

// clock rate of clk_i
`define MPC_CLK_MHZ 10
// low-power entry and exit times as printed
`define MPC_LP_ENTRY_NS 800
`define MPC_LP_EXIT_US 200
// entry is a least time (round up), exit a longest time (round down)
`define MPC_LP_ENTRY_CYC ((`MPC_LP_ENTRY_NS * `MPC_CLK_MHZ + 999) / 1000)
`define MPC_LP_EXIT_CYC (`MPC_LP_EXIT_US * `MPC_CLK_MHZ)
// rising test clocks with select high that reach logic reset
`define MPC_SCAN_RESET_TCKS 5

// pad indices of the dual-purpose pins
`define MPC_NPIN 13
`define MPC_PIN_DIAG_CLK 0
`define MPC_PIN_DIAG_SIN 1
`define MPC_PIN_DIAG_SOUT 2
`define MPC_PIN_PROBE_A 3
`define MPC_PIN_PROBE_B 4
`define MPC_PIN_TEST_CLK 5
`define MPC_PIN_TEST_DIN 6
`define MPC_PIN_TEST_DOUT 7
`define MPC_PIN_WIDE_DEC 8
`define MPC_PIN_QCLK0 9

// register byte offsets
`define MPC_REG_CTRL 8'h00
`define MPC_REG_PROBE_SEL 8'h04
`define MPC_REG_LOCK 8'h08
`define MPC_REG_STATUS 8'h0c

// control fields
`define MPC_CTRL_SCAN_RSV 0
`define MPC_CTRL_SCAN_DED 1
`define MPC_CTRL_WD_USED 2
`define MPC_CTRL_QCLK_LO 4
`define MPC_CTRL_RESET 8'h00
`define MPC_SEL_W 4

`endif

// ==== rtl/mpc_pin_ctrl.sv ====
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "mpc_consts.svh"
// Notes on behaviour
// - diag clock pin is input in mode
// - diag serial in only in mode
// - diag serial out driven in mode
// - checksum run drives diag serial out
// - probe pins show chosen nodes in mode
// - probe lock disables probing forever
// - low power tristates, blinds inputs, stops core
// - low power entry completes after 800 ns
// - normal operation resumes within 200 us
// - select low takes scan pins in flexible
// - scan pins freed at logic reset in flexible
// - five high test clocks reach reset
// - test data captured on test clock rise
// - dedicated mode follows standard select use
// - unreserved scan pins are user I/O
// - wide decode output drives reserved pin
// - unused quadrant clock pins are user I/O
module mpc_pin_ctrl
  import mpc_pkg::*;
#(
  parameter int NODES = 16,
  parameter int ENTRY_CYC = `MPC_LP_ENTRY_CYC,
  parameter int EXIT_CYC = `MPC_LP_EXIT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic mode_pin_i,
  input wire logic low_power_pin_i,
  input wire logic test_mode_sel_i,
  input wire logic [`MPC_NPIN-1:0] pad_i,
  output logic [`MPC_NPIN-1:0] pad_o,
  output logic [`MPC_NPIN-1:0] pad_oe_o,
  input wire logic [`MPC_NPIN-1:0] user_o_i,
  input wire logic [`MPC_NPIN-1:0] user_oe_i,
  output logic [`MPC_NPIN-1:0] user_in_o,
  input wire logic [NODES-1:0] design_node_i,
  input wire logic diag_sout_data_i,
  input wire logic checksum_active_i,
  input wire logic wide_decode_i,
  input wire logic scan_tdo_i,
  output logic diag_clk_o,
  output logic diag_sin_o,
  output logic scan_own_o,
  output logic scan_tms_o,
  output logic scan_tdi_o,
  output logic scan_capture_o,
  output logic [3:0] qclk_net_o,
  output logic core_enable_o
);
  localparam int NPIN = `MPC_NPIN;
  localparam int DIAG_CLOCK_PIN_P = `MPC_PIN_DIAG_CLK;
  localparam int SIN_P = `MPC_PIN_DIAG_SIN;
  localparam int SOUT_P = `MPC_PIN_DIAG_SOUT;
  localparam int PRA_P = `MPC_PIN_PROBE_A;
  localparam int PRB_P = `MPC_PIN_PROBE_B;
  localparam int TCK_P = `MPC_PIN_TEST_CLK;
  localparam int TDI_P = `MPC_PIN_TEST_DIN;
  localparam int TDO_P = `MPC_PIN_TEST_DOUT;
  localparam int WDO_P = `MPC_PIN_WIDE_DEC;
  localparam int QCK_P = `MPC_PIN_QCLK0;
  localparam logic [11:0] ENTRY_LAST = 12'(ENTRY_CYC - 1);
  // wake count leaves room for two synchroniser edges, the state change
  // and the output flop, so pins return inside the exit time (EXIT_CYC > 4)
  localparam logic [11:0] EXIT_LAST = 12'(EXIT_CYC - 5);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [NPIN-1:0] pad_s;
  logic mode_s;
  logic lp_s;
  logic tms_s;
  logic tck_prev;
  logic tck_rise;

  mpc_sync #(.W(NPIN + 3)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({pad_i, mode_pin_i, low_power_pin_i, test_mode_sel_i}),
    .sync_o({pad_s, mode_s, lp_s, tms_s})
  );

  // test clock edge found on the synchronised level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_prev <= 1'b0;
    end else begin
      tck_prev <= pad_s[TCK_P];
    end
  end
  assign tck_rise = pad_s[TCK_P] && !tck_prev;

  //////////////////////////////////////////////////////////////////////
  // registers over apb

  logic [7:0] ctrl;
  logic [7:0] probe_sel;
  logic probe_lock;
  logic [7:0] status;
  logic apb_setup;
  logic apb_write;
  mpc_lp_e lp_state;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `MPC_REG_CTRL) || (a == `MPC_REG_PROBE_SEL) ||
                 (a == `MPC_REG_LOCK) || (a == `MPC_REG_STATUS);
  endfunction

  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pready_o && pwrite_i;

  // answer is prepared at setup so the access phase has no wait
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup && !addr_known(paddr_i);
      prdata_o <= 32'h0000_0000;
      if (apb_setup && !pwrite_i) begin
        case (paddr_i)
          `MPC_REG_CTRL: prdata_o <= {24'h00_0000, ctrl};
          `MPC_REG_PROBE_SEL: prdata_o <= {24'h00_0000, probe_sel};
          `MPC_REG_LOCK: prdata_o <= {31'h0000_0000, probe_lock};
          `MPC_REG_STATUS: prdata_o <= {24'h00_0000, status};
          default: prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // control and probe selection
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= `MPC_CTRL_RESET;
      probe_sel <= 8'h00;
    end else if (apb_write) begin
      if (paddr_i == `MPC_REG_CTRL) begin
        ctrl <= pwdata_i[7:0];
      end
      if (paddr_i == `MPC_REG_PROBE_SEL) begin
        probe_sel <= pwdata_i[7:0];
      end
    end
  end

  // probe lock only sets; nothing but power-on reset clears it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      probe_lock <= 1'b0;
    end else if (apb_write && paddr_i == `MPC_REG_LOCK && pwdata_i[0]) begin
      probe_lock <= 1'b1;
    end
  end

  assign status = {2'b00, checksum_active_i, probe_lock, scan_own_o,
                   lp_state == MPC_LP_ASLEEP, core_enable_o, mode_s};

  //////////////////////////////////////////////////////////////////////
  // low-power sequencer

  logic [11:0] lp_cnt;
  logic asleep;

  // cycle counts come from parameters on the clk_i rate
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lp_state <= MPC_LP_AWAKE;
      lp_cnt <= 12'h000;
    end else begin
      lp_cnt <= lp_cnt + 12'h001;
      case (lp_state)
        MPC_LP_AWAKE: begin
          lp_cnt <= 12'h000;
          if (lp_s) begin
            lp_state <= MPC_LP_ENTER;
          end
        end
        MPC_LP_ENTER: begin
          if (!lp_s) begin
            lp_state <= MPC_LP_AWAKE;
          end else if (lp_cnt == ENTRY_LAST) begin
            lp_state <= MPC_LP_ASLEEP;
          end
        end
        MPC_LP_ASLEEP: begin
          lp_cnt <= 12'h000;
          if (!lp_s) begin
            lp_state <= MPC_LP_WAKE;
          end
        end
        MPC_LP_WAKE: begin
          if (lp_s) begin
            lp_state <= MPC_LP_ENTER;
            lp_cnt <= 12'h000;
          end else if (lp_cnt == EXIT_LAST) begin
            lp_state <= MPC_LP_AWAKE;
          end
        end
        default: lp_state <= MPC_LP_AWAKE;
      endcase
    end
  end

  // the pads stay dark until the wake time has fully run out
  assign asleep = (lp_state == MPC_LP_ASLEEP) || (lp_state == MPC_LP_WAKE);

  //////////////////////////////////////////////////////////////////////
  // boundary-scan ownership

  logic scan_own;
  logic tap_reset;

  mpc_scan_track u_scan (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .reserve_i(ctrl[`MPC_CTRL_SCAN_RSV]),
    .dedicated_i(ctrl[`MPC_CTRL_SCAN_DED]),
    .tck_rise_i(tck_rise),
    .tms_i(tms_s),
    .own_o(scan_own),
    .tap_reset_o(tap_reset)
  );

  // scan data taken only on a rising test clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scan_own_o <= 1'b0;
      scan_tms_o <= 1'b1;
      scan_tdi_o <= 1'b0;
      scan_capture_o <= 1'b0;
    end else begin
      scan_own_o <= scan_own;
      scan_tms_o <= tms_s;
      scan_capture_o <= scan_own && tck_rise && !asleep;
      if (scan_own && tck_rise) begin
        scan_tdi_o <= pad_s[TDI_P];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pad multiplexer

  logic [NPIN-1:0] next_pad_o;
  logic [NPIN-1:0] next_pad_oe;
  logic [NPIN-1:0] next_user_in;
  logic [3:0] qclk_used;
  logic probe_on;

  assign qclk_used = ctrl[`MPC_CTRL_QCLK_LO +: 4];
  assign probe_on = mode_s && !probe_lock;

  // start from user I/O, then let each special function take its pin
  always_comb begin
    next_pad_o = user_o_i;
    next_pad_oe = user_oe_i;
    next_user_in = pad_s;
    if (mode_s) begin
      next_pad_oe[DIAG_CLOCK_PIN_P] = 1'b0;
      next_user_in[DIAG_CLOCK_PIN_P] = 1'b0;
      next_pad_oe[SIN_P] = 1'b0;
      next_user_in[SIN_P] = 1'b0;
      next_user_in[PRA_P] = 1'b0;
      next_user_in[PRB_P] = 1'b0;
      next_pad_oe[PRA_P] = probe_on;
      next_pad_oe[PRB_P] = probe_on;
      next_pad_o[PRA_P] = probe_on &&
        design_node_i[probe_sel[`MPC_SEL_W-1:0]];
      next_pad_o[PRB_P] = probe_on &&
        design_node_i[probe_sel[2*`MPC_SEL_W-1:`MPC_SEL_W]];
    end
    if (mode_s || checksum_active_i) begin
      next_pad_oe[SOUT_P] = 1'b1;
      next_pad_o[SOUT_P] = diag_sout_data_i;
      next_user_in[SOUT_P] = 1'b0;
    end
    if (scan_own) begin
      next_pad_oe[TCK_P] = 1'b0;
      next_pad_oe[TDI_P] = 1'b0;
      next_pad_oe[TDO_P] = 1'b1;
      next_pad_o[TDO_P] = scan_tdo_i;
      next_user_in[TCK_P] = 1'b0;
      next_user_in[TDI_P] = 1'b0;
      next_user_in[TDO_P] = 1'b0;
    end
    if (ctrl[`MPC_CTRL_WD_USED]) begin
      next_pad_oe[WDO_P] = 1'b1;
      next_pad_o[WDO_P] = wide_decode_i;
    end
    for (int q = 0; q < 4; q++) begin
      if (qclk_used[q]) begin
        next_pad_oe[QCK_P + q] = 1'b0;
        next_user_in[QCK_P + q] = 1'b0;
      end
    end
    if (asleep) begin
      next_pad_oe = '0;
      next_user_in = '0;
    end
  end

  // every pad output comes from a flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_o <= '0;
      pad_oe_o <= '0;
      user_in_o <= '0;
      core_enable_o <= 1'b1;
    end else begin
      pad_o <= next_pad_o;
      pad_oe_o <= next_pad_oe;
      user_in_o <= next_user_in;
      core_enable_o <= !asleep;
    end
  end

  // diagnostic inputs and quadrant clock nets
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_clk_o <= 1'b0;
      diag_sin_o <= 1'b0;
      qclk_net_o <= 4'h0;
    end else begin
      diag_clk_o <= mode_s && !asleep && pad_s[DIAG_CLOCK_PIN_P];
      diag_sin_o <= mode_s && !asleep && pad_s[SIN_P];
      qclk_net_o <= asleep ? 4'h0 : (qclk_used & pad_s[QCK_P +: 4]);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // assertions

  a_sleep_dark: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) (lp_state == MPC_LP_ASLEEP)
      |=> (pad_oe_o == '0) && !core_enable_o && (user_in_o == '0))
    else $error("pads or core alive while asleep");

  a_entry_time: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) (lp_state == MPC_LP_ASLEEP)
      && ($past(lp_state) == MPC_LP_ENTER) |-> $past(lp_cnt) == ENTRY_LAST)
    else $error("low power entered at wrong time");

  a_exit_time: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) (lp_state == MPC_LP_AWAKE)
      && ($past(lp_state) == MPC_LP_WAKE) |-> $past(lp_cnt) == EXIT_LAST)
    else $error("low power left at wrong time");

  a_probe_locked: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) probe_lock && mode_s
      |=> !pad_oe_o[PRA_P] && !pad_oe_o[PRB_P])
    else $error("locked probe pin still drives");

  a_sout_drive: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) (mode_s || checksum_active_i)
      && !asleep |=> pad_oe_o[SOUT_P]
      && pad_o[SOUT_P] == $past(diag_sout_data_i))
    else $error("diag serial out not driven");

  a_diag_clock_pin_input: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) mode_s
      |=> !pad_oe_o[DIAG_CLOCK_PIN_P] && !pad_oe_o[SIN_P])
    else $error("diag input pin driven in mode");

  a_scan_release: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) scan_own && tap_reset && tms_s
      && !ctrl[`MPC_CTRL_SCAN_DED] |=> !scan_own ##1 !scan_own_o)
    else $error("scan pins not released at reset");

  a_scan_take: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) !scan_own && !tms_s && !asleep
      && ctrl[`MPC_CTRL_SCAN_RSV] |=> scan_own
      ##1 pad_oe_o[TDO_P] && !pad_oe_o[TCK_P])
    else $error("scan pins not taken on select low");

  a_tdi_capture: assert property (
    @(posedge clk_i) disable iff (!rst_n_i) scan_own && tck_rise
      |=> scan_tdi_o == $past(pad_s[TDI_P]))
    else $error("test data not captured on rise");

endmodule // mpc_pin_ctrl
`default_nettype wire

// ==== rtl/mpc_pkg.sv ====
package mpc_pkg;

  // low-power sequencer states
  typedef enum logic [3:0] {
    MPC_LP_AWAKE  = 4'b0001,
    MPC_LP_ENTER  = 4'b0010,
    MPC_LP_ASLEEP = 4'b0100,
    MPC_LP_WAKE   = 4'b1000
  } mpc_lp_e;

  // ownership of the scan pins
  typedef enum logic [1:0] {
    MPC_SCAN_FREE  = 2'b01,
    MPC_SCAN_OWNED = 2'b10
  } mpc_scan_e;

endpackage

// ==== rtl/mpc_scan_track.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "mpc_consts.svh"
module mpc_scan_track
  import mpc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reserve_i,
  input wire logic dedicated_i,
  input wire logic tck_rise_i,
  input wire logic tms_i,
  output logic own_o,
  output logic tap_reset_o
);
  localparam logic [2:0] RESET_TCKS = 3'(`MPC_SCAN_RESET_TCKS);
  mpc_scan_e state;
  logic [2:0] high_cnt;

  // count rising test clocks with select high, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      high_cnt <= RESET_TCKS;
    end else if (tck_rise_i) begin
      if (!tms_i) begin
        high_cnt <= 3'h0;
      end else if (high_cnt != RESET_TCKS) begin
        high_cnt <= high_cnt + 3'h1;
      end
    end
  end

  assign tap_reset_o = (high_cnt == RESET_TCKS);

  // flexible mode takes the pins on select low, frees them at reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= MPC_SCAN_FREE;
    end else begin
      case (state)
        MPC_SCAN_FREE: begin
          if (reserve_i && (dedicated_i || !tms_i)) begin
            state <= MPC_SCAN_OWNED;
          end
        end
        MPC_SCAN_OWNED: begin
          if (!reserve_i) begin
            state <= MPC_SCAN_FREE;
          end else if (!dedicated_i && tap_reset_o && tms_i) begin
            state <= MPC_SCAN_FREE;
          end
        end
        default: state <= MPC_SCAN_FREE;
      endcase
    end
  end

  assign own_o = (state == MPC_SCAN_OWNED);
endmodule // mpc_scan_track
`default_nettype wire

// ==== rtl/mpc_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module mpc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  // two flops; only the second stage is read outside
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule // mpc_sync
`default_nettype wire
